// file: rtl/cpdma_pkg.sv
package cpdma_pkg;
    typedef enum logic [1:0] {ARB_IDLE, ARB_TRY, ARB_OWN} cpdma_arb_t;
endpackage : cpdma_pkg

// file: rtl/cpdma_port_match.sv
`timescale 1ns/10ps
`include "cpdma_regs.svh"
module cpdma_port_match
    import cpdma_pkg::*;
(
    input wire logic [`CPDMA_ADDR_W-1:0] portAddr,
    input wire logic [`CPDMA_ADDR_W-1:0] strapGround,
    output logic portHit
);
    // bit i grounded reads 0, open reads 1; no storage
    function automatic logic [`CPDMA_ADDR_W-1:0] strapValue(
        input logic [`CPDMA_ADDR_W-1:0] gnd);
        strapValue = ~gnd;
    endfunction : strapValue

    // static strap compared combinationally
    assign portHit = (portAddr == strapValue(strapGround));
endmodule : cpdma_port_match

// file: rtl/cpdma_regs.svh
`ifndef CPDMA_REGS_SVH
`define CPDMA_REGS_SVH
`define CPDMA_ADDR_W 8
`define CPDMA_DATA_W 8
`define CPDMA_CMD_RST 8'h00
`endif

// file: rtl/cpdma_top.sv
`timescale 1ns/10ps
`include "cpdma_regs.svh"
module cpdma_top
    import cpdma_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hostOutCycle,
    input wire logic [`CPDMA_ADDR_W-1:0] hostPortAddr,
    input wire logic [`CPDMA_DATA_W-1:0] hostData,
    input wire logic [`CPDMA_ADDR_W-1:0] strapGround,
    input wire logic phaseClk,
    input wire logic priority_chain_in_n,
    input wire logic holdLineIn_n,
    input wire logic dmaRequest,
    input wire logic cmdRead,
    output logic holdOut_n,
    output logic priority_chain_out_n,
    output logic command_pending_n,
    output logic [`CPDMA_DATA_W-1:0] cmdData,
    output logic dmaGranted,
    output logic dmaAborted
);
    typedef struct packed {
        logic [1:0] outSync;
        logic [1:0] phaseSync;
        logic [1:0] priSync;
        logic [1:0] holdSync;
        logic [1:0][`CPDMA_ADDR_W-1:0] addrSync;
        logic [1:0][`CPDMA_DATA_W-1:0] dataSync;
        logic outPrev;
        logic phasePrev;
        logic pending;
        logic [`CPDMA_DATA_W-1:0] data;
        cpdma_arb_t arb;
        logic abortPulse;
    } cpdma_state_t;

    cpdma_state_t st_reg;
    cpdma_state_t st_next;
    logic portHit;
    logic outRise;
    logic phaseFall;
    logic priOk;
    logic holdFree;

    cpdma_port_match u_match (
        .portAddr(st_reg.addrSync[1]),
        .strapGround(strapGround),
        .portHit(portHit)
    );

    // edge and level views of synchronised pins
    assign outRise = st_reg.outSync[1] & ~st_reg.outPrev;
    assign phaseFall = ~st_reg.phaseSync[1] & st_reg.phasePrev;
    assign priOk = st_reg.priSync[1];
    assign holdFree = st_reg.holdSync[1];

    // next state
    always_comb begin
        st_next = st_reg;
        st_next.outSync = {st_reg.outSync[0], hostOutCycle};
        st_next.phaseSync = {st_reg.phaseSync[0], phaseClk};
        st_next.priSync = {st_reg.priSync[0], priority_chain_in_n};
        st_next.holdSync = {st_reg.holdSync[0], holdLineIn_n};
        // address and data pins pass two stages like their strobe
        st_next.addrSync = {st_reg.addrSync[0], hostPortAddr};
        st_next.dataSync = {st_reg.dataSync[0], hostData};
        st_next.outPrev = st_reg.outSync[1];
        st_next.phasePrev = st_reg.phaseSync[1];
        st_next.abortPulse = 1'b0;
        // read clears first, a new write wins over it
        if (cmdRead) begin
            st_next.pending = 1'b0;
        end
        if (outRise && portHit) begin
            st_next.data = st_reg.dataSync[1];
            st_next.pending = 1'b1;
        end
        case (st_reg.arb)
            ARB_IDLE: begin
                // wait for free chain and free hold line
                if (dmaRequest && priOk && holdFree && phaseFall) begin
                    st_next.arb = ARB_TRY;
                end
            end
            ARB_TRY: begin
                if (!priOk) begin
                    st_next.arb = ARB_IDLE;
                    st_next.abortPulse = 1'b1;
                end else if (!dmaRequest) begin
                    // request withdrawn before the bus was won
                    st_next.arb = ARB_IDLE;
                end else if (phaseFall) begin
                    st_next.arb = ARB_OWN;
                end
            end
            ARB_OWN: begin
                // keep bus until own transfer done
                if (!dmaRequest) begin
                    st_next.arb = ARB_IDLE;
                end
            end
            default: begin
                st_next.arb = ARB_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '{outSync: 2'h0, phaseSync: 2'h0, priSync: 2'h3,
                holdSync: 2'h3, addrSync: 16'h0000, dataSync: 16'h0000,
                outPrev: 1'b0, phasePrev: 1'b0,
                pending: 1'b0, data: `CPDMA_CMD_RST, arb: ARB_IDLE,
                abortPulse: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs
    assign holdOut_n = ~(st_reg.pending | (st_reg.arb != ARB_IDLE));
    assign priority_chain_out_n = priOk & (st_reg.arb == ARB_IDLE);
    assign command_pending_n = ~st_reg.pending;
    assign cmdData = st_reg.data;
    assign dmaGranted = (st_reg.arb == ARB_OWN);
    assign dmaAborted = st_reg.abortPulse;
endmodule : cpdma_top

// file: tb/cpdma_partner.sv
`timescale 1ns/10ps
module cpdma_partner(input wire logic clk, grab, holdOut_n,
    output logic phaseClk, priority_chain_in_n, holdLineIn_n);
    logic [2:0] div = 3'h0;
    // host phase every 8 clk; grab is a higher controller's transfer
    always @(posedge clk) div <= div + 3'h1;
    assign phaseClk = div[2];
    assign priority_chain_in_n = ~grab;
    assign holdLineIn_n = holdOut_n & ~grab;
endmodule : cpdma_partner

// file: tb/cpdma_top_assertions.sv
`timescale 1ns/10ps
module cpdma_top_assertions(input wire logic clk, rst_n, dmaRequest,
    input wire logic priority_chain_in_n, priority_chain_out_n, holdOut_n,
    input wire logic command_pending_n, dmaGranted, dmaAborted);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_own; dmaGranted && !dmaRequest && command_pending_n; endsequence
    a_pend_hold:
        assert property (!command_pending_n |-> !holdOut_n) else $error("p");
    a_own_pri:
        assert property (dmaGranted |-> !priority_chain_out_n) else $error("o");
    a_chain_pass:
        assert property (!$past(priority_chain_in_n, 2) &&
            !$past(priority_chain_in_n, 3) |-> !priority_chain_out_n)
        else $error("c");
    a_abort_once:
        assert property (dmaAborted |=> !dmaAborted) else $error("a");
    a_abort_try:
        assert property (dmaAborted |-> !dmaGranted) else $error("t");
    a_grant_req:
        assert property ($rose(dmaGranted) |-> $past(dmaRequest)) else $error("r");
    a_own_end:
        assert property (s_own |=> !dmaGranted && holdOut_n) else $error("e");
    a_own_keep:
        assert property (dmaGranted && dmaRequest |=> dmaGranted) else $error("k");
endmodule : cpdma_top_assertions
bind cpdma_top cpdma_top_assertions cpdma_top_assertions_i(.*);

// file: tb/tb_command_port_decode_dma_priority.sv
`timescale 1ns/10ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin \
    bad_count++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb_command_port_decode_dma_priority;
    logic clk = 0, rst_n = 0, hostOutCycle = 0, grab = 0, dmaRequest = 0;
    logic cmdRead = 0, phaseClk, priority_chain_in_n, holdLineIn_n, holdOut_n;
    logic priority_chain_out_n, command_pending_n, dmaGranted, dmaAborted;
    logic [7:0] hostPortAddr = 0, hostData = 0, strapGround = 0, cmdData;
    int bad_count = 0, check_count = 0;
    always #5 clk = ~clk;
    cpdma_top cpdma_top_i(.*);
    cpdma_partner cpdma_partner_i(.*);
    task step(int n); repeat (n) @(posedge clk); #1; endtask : step
    task hostWrite(logic [7:0] a, d);
        {hostPortAddr, hostData, hostOutCycle} = {a, d, 1'b1}; step(5);
        hostOutCycle = 1'b0; step(3);
    endtask : hostWrite
    // strap decode, refused address, latch and clear by local read
    task t_cmd(logic [7:0] a);
        strapGround = ~a; hostWrite(a ^ 8'h01, 8'h5A);
        `CHK("ref", 1'b1, command_pending_n)
        hostWrite(a, ~a); `CHK("pend", 1'b0, command_pending_n)
        `CHK("data", ~a, cmdData)
        `CHK("hold", 1'b0, holdOut_n)
        cmdRead = 1'b1; step(1); cmdRead = 1'b0; step(1);
        `CHK("clr", 1'b1, command_pending_n)
        `CHK("unhold", 1'b1, holdOut_n)
    endtask : t_cmd
    // aborted by a higher controller, locked out, then granted
    task t_arb;
        dmaRequest = 1'b1;
        repeat (40) if (priority_chain_out_n !== 1'b0) step(1);
        `CHK("tryhold", 1'b0, holdOut_n)
        grab = 1'b1; repeat (8) if (dmaAborted !== 1'b1) step(1);
        `CHK("abort", 1'b1, dmaAborted)
        step(30); `CHK("lock", 1'b0, dmaGranted)
        `CHK("passlow", 1'b0, priority_chain_out_n)
        grab = 1'b0; repeat (40) if (dmaGranted !== 1'b1) step(1);
        `CHK("grant", 1'b1, dmaGranted)
        `CHK("ownpri", 1'b0, priority_chain_out_n)
        dmaRequest = 1'b0; step(2);
        `CHK("release", 1'b1, holdOut_n)
    endtask : t_arb
    task results;
        $display("checks %0d errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : results
    initial begin
        repeat (8) @(posedge clk); #1 rst_n = 1'b1;
        step(4); t_cmd(8'hFD); t_cmd(8'hF6); t_arb; results;
    end
    // watchdog
    initial begin #20000 bad_count++; results; end
endmodule : tb_command_port_decode_dma_priority
